// ==== src/dram_cfg_pkg.sv ====
// Constants, field layouts and carriers for the DRAM and wait-area configuration block
//////////////////////////////////////////////////////////////////////////////
// Function
// - Wait input pull-up on when bit 15 is 1, the reset state.
// - Areas 0 and 2 long wait is 1 to 4 cycles, reset 4.
// - Area 6 long wait is 1 to 4 cycles from own field, reset 4.
// - Bit 0 selects two column strobes, bit 1 selects two write strobes.
// - Row strobe returns high after access, or stays low when hold set.
// - One precharge cycle when bit is 0, two when bit is 1.
// - Bit 0 gives full accesses, bit 1 gives fast page burst.
// - Column strobe high time is 50 percent, or 35 percent when set.
// - Multiplex bit 1 puts row and column on the same lines.
// - Row shift is 8, 9 or 10 bits; code 11 is reserved.
// - Non-multiplexed burst row is address 27 down to 8, 9 or 10.
// - Long wait adds to one base cycle, optionally extended by wait pin.
//////////////////////////////////////////////////////////////////////////////
package dram_cfg_pkg;

  // Register indices as printed; byte address is four times the index
  localparam logic [27:0] WAIT_CTRL_IDX   = 28'h5FFFFA6;
  localparam logic [27:0] DRAM_CTRL_IDX   = 28'h5FFFFA8;
  localparam logic [31:0] WAIT_CTRL_ADDR  = {2'h0, WAIT_CTRL_IDX, 2'h0};
  localparam logic [31:0] DRAM_CTRL_ADDR  = {2'h0, DRAM_CTRL_IDX, 2'h0};

  // Values after reset and masks of implemented bits
  localparam logic [15:0] WAIT_CTRL_RESET = 16'hF800;
  localparam logic [15:0] DRAM_CTRL_RESET = 16'h0000;
  localparam logic [15:0] WAIT_CTRL_MASK  = 16'hF800;
  localparam logic [15:0] DRAM_CTRL_MASK  = 16'hFF00;

  // Field positions
  localparam int PULLUP_BIT   = 15;
  localparam int AREA02_LSB   = 13;
  localparam int AREA6_LSB    = 11;
  localparam int SHIFT_LSB    = 8;

  // Shift count encodings and reserved code
  localparam logic [1:0] SHIFT_RESERVED = 2'h3;
  localparam logic [3:0] SHIFT_BASE     = 4'h8;

  // Column strobe high time in percent
  localparam logic [6:0] DUTY_NORMAL_PCT = 7'h32;
  localparam logic [6:0] DUTY_SHORT_PCT  = 7'h23;

  // Avalon response codes
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_ERROR = 2'h2;

  // Wait sequencer states
  typedef enum logic [1:0] {
    WS_IDLE = 2'b00,
    WS_BASE = 2'b01,
    WS_LONG = 2'b10,
    WS_PIN  = 2'b11
  } wait_state_e;

  // Wait and pull-up settings
  typedef struct packed {
    logic       wait_pullup_en;
    logic [1:0] area02_longwait;
    logic [1:0] area6_longwait;
  } wait_cfg_s;

  // DRAM access settings
  typedef struct packed {
    logic       strobe_scheme_sel;
    logic       row_strobe_hold;
    logic       precharge_len;
    logic       page_burst_en;
    logic       col_strobe_duty;
    logic       addr_mux_en;
    logic [1:0] row_shift;
  } dram_cfg_s;

endpackage

// ==== src/dram_wait_area_config.sv ====
// Register file and derived timing for the DRAM and long-wait area configuration
//
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module dram_wait_area_config #(
  parameter int ADDR_W = 28
) (
  // Clock, reset and clock enable
  input  wire logic                  clock,
  input  wire logic                  reset,
  input  wire logic                  clock_en,
  // Avalon-MM register slave
  input  wire logic [31:0]           address,
  input  wire logic                  read,
  input  wire logic                  write,
  input  wire logic [3:0]            byteenable,
  input  wire logic [31:0]           writedata,
  output logic      [31:0]           readdata,
  output logic                       waitrequest,
  output logic      [1:0]            response,
  // Settings as seen by the cycle sequencer
  output dram_cfg_pkg::wait_cfg_s    wait_cfg,
  output dram_cfg_pkg::dram_cfg_s    dram_cfg,
  output logic      [2:0]            area02_wait_cycles,
  output logic      [2:0]            area6_wait_cycles,
  output logic      [1:0]            precharge_cycles,
  output logic      [6:0]            col_strobe_high_pct,
  output logic      [3:0]            row_shift_bits,
  // Wait pin pull-up
  output logic                       wait_pullup_en,
  // Long-wait sequencer
  input  wire logic                  access_start,
  input  wire logic [2:0]            access_area,
  input  wire logic                  wait_sample_en,
  input  wire logic                  wait_pin_n,
  output logic                       access_busy,
  output logic                       access_done,
  // Strobe generation
  input  wire logic                  col_strobe_req,
  input  wire logic                  write_req,
  input  wire logic                  lane_hi,
  input  wire logic                  lane_lo,
  output logic                       col_strobe_high_byte_n,
  output logic                       col_strobe_low_byte_n,
  output logic                       write_strobe_high_byte_n,
  output logic                       write_strobe_low_byte_n,
  // Address multiplexing
  input  wire logic [ADDR_W-1:0]     access_addr,
  input  wire logic                  row_phase,
  output logic      [ADDR_W-1:0]     dram_addr_out,
  output logic      [ADDR_W-1:0]     burst_row_addr
);

  //////////////////////////////////////////////////////////////////////////////
  // Elaboration check: the row field must reach past the widest shift
  if (ADDR_W < 11 || ADDR_W > 32) begin : g_bad_width
    $error("ADDR_W must lie between 11 and 32");
  end

  // Elaboration check: reset values may only set implemented bits
  if (|(dram_cfg_pkg::WAIT_CTRL_RESET & ~dram_cfg_pkg::WAIT_CTRL_MASK) ||
      |(dram_cfg_pkg::DRAM_CTRL_RESET & ~dram_cfg_pkg::DRAM_CTRL_MASK)) begin : g_bad_reset
    $error("Register reset values set unimplemented bits");
  end

  // Elaboration check: the two registers must decode to distinct addresses
  if (dram_cfg_pkg::WAIT_CTRL_ADDR == dram_cfg_pkg::DRAM_CTRL_ADDR) begin : g_bad_map
    $error("Register addresses overlap");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Two-bit long-wait code to a count of 1 to 4 cycles
  function automatic logic [2:0] long_wait_cycles(input logic [1:0] code);
    long_wait_cycles = {1'b0, code} + 3'h1;
  endfunction

  // Two-bit shift code to a count of 8 to 10 bits
  function automatic logic [3:0] shift_bits(input logic [1:0] code);
    shift_bits = dram_cfg_pkg::SHIFT_BASE + {2'h0, code};
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Register bus decode

  // Register storage; unused bits are held at zero
  logic [15:0] wait_reg;
  logic [15:0] dram_reg;

  // Handshake and write strobes
  wire logic        request    = read | write;
  wire logic        hit_wait   = address == dram_cfg_pkg::WAIT_CTRL_ADDR;
  wire logic        hit_dram   = address == dram_cfg_pkg::DRAM_CTRL_ADDR;
  wire logic        hit_any    = hit_wait | hit_dram;
  wire logic        accept     = request & ~waitrequest;
  wire logic        do_write   = accept & write;
  wire logic        next_wait  = ~(request & waitrequest);

  // Byte-lane merge; only the upper byte holds settings
  wire logic [15:0] lane_mask  = {{8{byteenable[1]}}, {8{byteenable[0]}}};
  wire logic [15:0] wait_merge = (wait_reg & ~lane_mask) | (writedata[15:0] & lane_mask);
  wire logic [15:0] dram_merge = (dram_reg & ~lane_mask) | (writedata[15:0] & lane_mask);

  // Reserved shift code leaves the old code in place
  wire logic        shift_bad  =
    dram_merge[dram_cfg_pkg::SHIFT_LSB +: 2] == dram_cfg_pkg::SHIFT_RESERVED;
  wire logic [15:0] dram_legal = shift_bad
    ? {dram_merge[15:10], dram_reg[9:8], dram_merge[7:0]} : dram_merge;

  // Unused bits are masked on write and on read
  wire logic [15:0] next_wait_reg = wait_merge & dram_cfg_pkg::WAIT_CTRL_MASK;
  wire logic [15:0] next_dram_reg = dram_legal & dram_cfg_pkg::DRAM_CTRL_MASK;

  // Read mux; an unmapped address reads as zero
  wire logic [15:0] read_sel =
    hit_wait ? (wait_reg & dram_cfg_pkg::WAIT_CTRL_MASK) :
    hit_dram ? (dram_reg & dram_cfg_pkg::DRAM_CTRL_MASK) : 16'h0000;

  //////////////////////////////////////////////////////////////////////////////
  // Bus handshake: one wait cycle, then data and acknowledge together
  always_ff @(posedge clock) begin
    if (reset) begin
      waitrequest <= 1'b1;
      readdata    <= 32'h0000_0000;
      response    <= dram_cfg_pkg::RESP_OKAY;
    end else if (clock_en) begin
      waitrequest <= next_wait;
      if (request && waitrequest) begin
        readdata <= {16'h0000, read_sel};
        response <= hit_any ? dram_cfg_pkg::RESP_OKAY : dram_cfg_pkg::RESP_ERROR;
      end
    end
  end

  // Register storage
  always_ff @(posedge clock) begin
    if (reset) begin
      wait_reg <= dram_cfg_pkg::WAIT_CTRL_RESET;
      dram_reg <= dram_cfg_pkg::DRAM_CTRL_RESET;
    end else if (clock_en && do_write) begin
      if (hit_wait) begin
        wait_reg <= next_wait_reg;
      end
      if (hit_dram) begin
        dram_reg <= next_dram_reg;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Field views

  // Fields of the wait register
  wire dram_cfg_pkg::wait_cfg_s wfld = '{
    wait_pullup_en:  wait_reg[dram_cfg_pkg::PULLUP_BIT],
    area02_longwait: wait_reg[dram_cfg_pkg::AREA02_LSB +: 2],
    area6_longwait:  wait_reg[dram_cfg_pkg::AREA6_LSB +: 2]
  };
  // Fields of the DRAM register
  wire dram_cfg_pkg::dram_cfg_s dfld = dram_reg[15:8];

  // Counts, percentage and shift derived from the fields
  wire logic [2:0] lw02      = long_wait_cycles(wfld.area02_longwait);
  wire logic [2:0] lw6       = long_wait_cycles(wfld.area6_longwait);
  wire logic [3:0] shift_cnt = shift_bits(dfld.row_shift);
  wire logic [1:0] pre_cyc   = dfld.precharge_len ? 2'h2 : 2'h1;
  wire logic [6:0] duty_pct  = dfld.col_strobe_duty
    ? dram_cfg_pkg::DUTY_SHORT_PCT : dram_cfg_pkg::DUTY_NORMAL_PCT;

  // Settings out, one flop behind the registers
  always_ff @(posedge clock) begin
    if (reset) begin
      wait_cfg            <= dram_cfg_pkg::WAIT_CTRL_RESET[15:11];
      dram_cfg            <= dram_cfg_pkg::DRAM_CTRL_RESET[15:8];
      area02_wait_cycles  <= 3'h4;
      area6_wait_cycles   <= 3'h4;
      precharge_cycles    <= 2'h1;
      col_strobe_high_pct <= dram_cfg_pkg::DUTY_NORMAL_PCT;
      row_shift_bits      <= dram_cfg_pkg::SHIFT_BASE;
      wait_pullup_en      <= 1'b1;
    end else if (clock_en) begin
      wait_cfg            <= wfld;
      dram_cfg            <= dfld;
      area02_wait_cycles  <= lw02;
      area6_wait_cycles   <= lw6;
      precharge_cycles    <= pre_cyc;
      col_strobe_high_pct <= duty_pct;
      row_shift_bits      <= shift_cnt;
      wait_pullup_en      <= wfld.wait_pullup_en;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Wait pin synchroniser, three stages, change taken when last two agree

  // Stages and filtered wait level
  logic       pin_s1;
  logic       pin_s2;
  logic       pin_s3;
  logic       pin_wait;
  wire  logic pin_agree = pin_s2 == pin_s3;

  always_ff @(posedge clock) begin
    if (reset) begin
      pin_s1   <= 1'b1;
      pin_s2   <= 1'b1;
      pin_s3   <= 1'b1;
      pin_wait <= 1'b0;
    end else if (clock_en) begin
      pin_s1 <= wait_pin_n;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      if (pin_agree) begin
        pin_wait <= ~pin_s3;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Long-wait sequencer: base cycle, long wait, then optional pin extension

  // State and remaining long-wait count
  dram_cfg_pkg::wait_state_e state;
  dram_cfg_pkg::wait_state_e next_state;
  logic [2:0]                count;
  logic [2:0]                next_count;

  // Access options latched when the access is taken
  logic                      long_area;
  logic                      sample_en;
  logic                      next_done;

  // Areas 0, 2 and 6 carry a long wait
  wire logic       is_long   = access_area == 3'h0 || access_area == 3'h2 ||
                               access_area == 3'h6;
  wire logic [2:0] area_wait = access_area == 3'h6 ? lw6 : lw02;

  // Next-state decode
  always_comb begin
    next_state = state;
    next_count = count;
    next_done  = 1'b0;
    unique case (state)
      dram_cfg_pkg::WS_IDLE: begin
        if (access_start) begin
          next_state = dram_cfg_pkg::WS_BASE;
        end
      end
      dram_cfg_pkg::WS_BASE: begin
        if (long_area) begin
          next_state = dram_cfg_pkg::WS_LONG;
        end else begin
          next_state = dram_cfg_pkg::WS_IDLE;
          next_done  = 1'b1;
        end
      end
      dram_cfg_pkg::WS_LONG: begin
        if (count > 3'h1) begin
          next_count = count - 3'h1;
        end else if (sample_en && pin_wait) begin
          next_state = dram_cfg_pkg::WS_PIN;
        end else begin
          next_state = dram_cfg_pkg::WS_IDLE;
          next_done  = 1'b1;
        end
      end
      dram_cfg_pkg::WS_PIN: begin
        if (!pin_wait) begin
          next_state = dram_cfg_pkg::WS_IDLE;
          next_done  = 1'b1;
        end
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clock) begin
    if (reset) begin
      state       <= dram_cfg_pkg::WS_IDLE;
      count       <= 3'h0;
      long_area   <= 1'b0;
      sample_en   <= 1'b0;
      access_busy <= 1'b0;
      access_done <= 1'b0;
    end else if (clock_en) begin
      state       <= next_state;
      count       <= next_count;
      access_done <= next_done;
      access_busy <= next_state != dram_cfg_pkg::WS_IDLE;
      if (state == dram_cfg_pkg::WS_IDLE && access_start) begin
        long_area <= is_long;
        sample_en <= wait_sample_en;
        count     <= area_wait;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Strobes, active low

  // Lane decode for the selected strobe scheme
  wire logic two_we   = dfld.strobe_scheme_sel;
  wire logic cas_hi   = col_strobe_req & lane_hi & ~two_we;
  wire logic cas_lo   = col_strobe_req & (two_we | lane_lo);
  wire logic we_hi    = write_req & two_we & lane_hi;
  wire logic we_lo    = write_req & (two_we ? lane_lo : 1'b1);

  // Two-column scheme uses one write strobe; two-write scheme one column strobe
  always_ff @(posedge clock) begin
    if (reset) begin
      col_strobe_high_byte_n   <= 1'b1;
      col_strobe_low_byte_n    <= 1'b1;
      write_strobe_high_byte_n <= 1'b1;
      write_strobe_low_byte_n  <= 1'b1;
    end else if (clock_en) begin
      col_strobe_high_byte_n   <= ~cas_hi;
      col_strobe_low_byte_n    <= ~cas_lo;
      write_strobe_high_byte_n <= ~we_hi;
      write_strobe_low_byte_n  <= ~we_lo;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Address multiplexing and burst row extraction

  // Row address shifted down by the programmed count
  wire logic [ADDR_W-1:0] row_addr = access_addr >> shift_cnt;
  wire logic [ADDR_W-1:0] mux_addr =
    (dfld.addr_mux_en && row_phase) ? row_addr : access_addr;

  // Row field for burst without multiplexing; code 11 never stored
  always_ff @(posedge clock) begin
    if (reset) begin
      dram_addr_out  <= '0;
      burst_row_addr <= '0;
    end else if (clock_en) begin
      dram_addr_out  <= mux_addr;
      burst_row_addr <= row_addr;
    end
  end

endmodule // dram_wait_area_config

`default_nettype wire

// ==== dv/dram_mem_partner.sv ====
// External memory model that stretches accesses through the wait pin
`timescale 1ns/1ps
`default_nettype none

module dram_mem_partner (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       reset,
  // Stall command from the bench
  input  wire logic       go,
  input  wire logic [4:0] stall,
  // Wait pin, active low
  output logic            wait_pin_n
);
  logic [4:0] left;

  // Count down the commanded stall
  always_ff @(posedge clock) begin
    if (reset) left <= 5'h00;
    else if (go) left <= stall;
    else if (left != 5'h00) left <= left - 5'h01;
  end

  // Released pin sits at the pull-up level
  assign wait_pin_n = (left == 5'h00);
endmodule  // dram_mem_partner
`default_nettype wire

// ==== dv/dram_cfg_checker.sv ====
// Concurrent checks on the configuration block ports
`timescale 1ns/1ps
`default_nettype none

module dram_cfg_checker #(
  parameter int ADDR_W = 28
) (
  // Clock and reset
  input wire logic                    clock,
  input wire logic                    reset,
  // Register bus
  input wire logic                    read,
  input wire logic                    write,
  input wire logic                    waitrequest,
  // Settings
  input wire dram_cfg_pkg::wait_cfg_s wait_cfg,
  input wire dram_cfg_pkg::dram_cfg_s dram_cfg,
  input wire logic [2:0]              area02_wait_cycles,
  input wire logic [2:0]              area6_wait_cycles,
  input wire logic [1:0]              precharge_cycles,
  input wire logic [6:0]              col_strobe_high_pct,
  input wire logic [3:0]              row_shift_bits,
  input wire logic                    wait_pullup_en,
  // Sequencer, strobes and address
  input wire logic                    access_start,
  input wire logic [2:0]              access_area,
  input wire logic                    wait_sample_en,
  input wire logic                    access_busy,
  input wire logic                    access_done,
  input wire logic                    write_strobe_high_byte_n,
  input wire logic [ADDR_W-1:0]       access_addr,
  input wire logic [ADDR_W-1:0]       dram_addr_out
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  a_pullup_follows: assert property (wait_pullup_en == wait_cfg.wait_pullup_en)
    else $error("pull-up output differs from its field");
  a_area02_count: assert property (area02_wait_cycles == wait_cfg.area02_longwait + 3'h1)
    else $error("area 0/2 long wait count wrong");
  a_area6_count: assert property (area6_wait_cycles == wait_cfg.area6_longwait + 3'h1)
    else $error("area 6 long wait count wrong");
  a_precharge_count: assert property (precharge_cycles == (dram_cfg.precharge_len ? 2'h2 : 2'h1))
    else $error("precharge count wrong");
  a_duty_pct: assert property (col_strobe_high_pct == (dram_cfg.col_strobe_duty ? 7'h23 : 7'h32))
    else $error("column strobe duty wrong");
  a_shift_bits: assert property (row_shift_bits == 4'h8 + dram_cfg.row_shift)
    else $error("row shift count wrong");
  a_shift_legal: assert property (dram_cfg.row_shift != 2'h3)
    else $error("reserved shift code accepted");
  a_bus_one_wait: assert property ((read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
    else $error("bus answer not after one wait cycle");
  a_scheme_we: assert property (!dram_cfg.strobe_scheme_sel |-> write_strobe_high_byte_n)
    else $error("high write strobe active in two-column mode");
  a_mux_off_addr: assert property (!dram_cfg.addr_mux_en |-> dram_addr_out == $past(access_addr))
    else $error("address changed without multiplexing");
  a_short_done: assert property (access_start && !access_busy && access_area == 3'h1 |-> ##2 access_done)
    else $error("short area access length wrong");
  a_long6_done: assert property (access_start && !access_busy && access_area == 3'h6 && !wait_sample_en
    && area6_wait_cycles == 3'h4 |-> !access_done [*6] ##1 access_done)
    else $error("area 6 long access length wrong");
  a_reset_values: assert property ($fell(reset) |-> wait_pullup_en && wait_cfg == 5'h1F
    && dram_cfg == 8'h00)
    else $error("settings after reset wrong");
  a_done_pulse: assert property (access_done |=> !access_done)
    else $error("access done longer than one cycle");
endmodule  // dram_cfg_checker

bind dram_wait_area_config dram_cfg_checker #(.ADDR_W(ADDR_W)) u_dram_cfg_checker (.clock, .reset,
  .read, .write, .waitrequest, .wait_cfg, .dram_cfg, .area02_wait_cycles, .area6_wait_cycles,
  .precharge_cycles, .col_strobe_high_pct, .row_shift_bits, .wait_pullup_en, .access_start,
  .access_area, .wait_sample_en, .access_busy, .access_done, .write_strobe_high_byte_n,
  .access_addr, .dram_addr_out);
`default_nettype wire

// ==== dv/tb.sv ====
// Self-checking bench for the DRAM and wait-area configuration block
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic        clock, reset, clock_en, read, write, access_start, wait_sample_en, wait_pin_n, go;
  logic        col_strobe_req, write_req, lane_hi, lane_lo, row_phase, waitrequest;
  logic        access_busy, access_done, wait_pullup_en, col_strobe_high_byte_n;
  logic        col_strobe_low_byte_n, write_strobe_high_byte_n, write_strobe_low_byte_n;
  logic [31:0] address, writedata, readdata, q;
  logic [27:0] access_addr, dram_addr_out, burst_row_addr, a;
  logic [15:0] d, e, old;
  logic [6:0]  col_strobe_high_pct;
  logic [4:0]  stall;
  logic [3:0]  byteenable, row_shift_bits;
  logic [2:0]  access_area, area02_wait_cycles, area6_wait_cycles;
  logic [1:0]  response, precharge_cycles, r;
  dram_cfg_pkg::wait_cfg_s wait_cfg;
  dram_cfg_pkg::dram_cfg_s dram_cfg;
  int          fail_count, comparisons, c, n;

  dram_wait_area_config u_dram_wait_area_config (.clock, .reset, .clock_en, .address, .read,
    .write, .byteenable, .writedata, .readdata, .waitrequest, .response, .wait_cfg, .dram_cfg,
    .area02_wait_cycles, .area6_wait_cycles, .precharge_cycles, .col_strobe_high_pct,
    .row_shift_bits, .wait_pullup_en, .access_start, .access_area, .wait_sample_en, .wait_pin_n,
    .access_busy, .access_done, .col_strobe_req, .write_req, .lane_hi, .lane_lo,
    .col_strobe_high_byte_n, .col_strobe_low_byte_n, .write_strobe_high_byte_n,
    .write_strobe_low_byte_n, .access_addr, .row_phase, .dram_addr_out, .burst_row_addr);
  dram_mem_partner u_dram_mem_partner (.clock, .reset, .go, .stall, .wait_pin_n);

  // Clock generator
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // One bus transfer, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [31:0] ad, input logic [15:0] dw);
    n = 0;
    address <= ad; writedata <= {16'h0000, dw}; write <= wr; read <= !wr;
    do begin @(posedge clock); n++; end while (waitrequest !== 1'b0 && n < 50);
    q = readdata; r = response;
    read <= 1'b0; write <= 1'b0;
    @(posedge clock);
    if (n >= 50) fail_count++;
  endtask

  // One sequencer access; c counts edges until done is seen
  task automatic seq(input logic [2:0] ar, input logic se, input logic [4:0] st);
    stall <= st; go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    repeat (4) @(posedge clock);
    access_start <= 1'b1; access_area <= ar; wait_sample_en <= se;
    @(posedge clock);
    access_start <= 1'b0; c = 0;
    do begin
      @(posedge clock);
      c++;
      if (c == 1) chk(access_busy, 1'b1);
    end while (access_done !== 1'b1 && c < 60);
    @(posedge clock);
  endtask

  function automatic logic [15:0] dexp(input logic [15:0] o, input logic [15:0] w);
    dexp = w & 16'hFF00;
    if (dexp[9:8] == 2'h3) dexp[9:8] = o[9:8];
  endfunction

  // Strobe levels for k = {lane_lo, lane_hi, write_req, col_strobe_req}
  function automatic logic [3:0] sexp(input logic s, input logic [3:0] k);
    if (!s) return {~(k[0] & k[2]), ~(k[0] & k[3]), 1'b1, ~k[1]};
    return {1'b1, ~k[0], ~(k[1] & k[2]), ~(k[1] & k[3])};
  endfunction

  // Watchdog
  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    {read, write, access_start, wait_sample_en, go, col_strobe_req, write_req} = '0;
    {lane_hi, lane_lo, row_phase, address, writedata, access_addr, stall, access_area} = '0;
    reset = 1'b1; clock_en = 1'b1; byteenable = 4'hF; fail_count = 0; comparisons = 0;
    void'($urandom(32'h2947B87E));
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    bus(1'b0, dram_cfg_pkg::WAIT_CTRL_ADDR, 16'h0000);
    chk(q, 32'h0000F800);
    chk(r, 2'h0);
    bus(1'b0, dram_cfg_pkg::DRAM_CTRL_ADDR, 16'h0000);
    chk(q, 32'h00000000);
    chk({wait_pullup_en, area02_wait_cycles, area6_wait_cycles}, 7'h64);
    chk({precharge_cycles, col_strobe_high_pct, row_shift_bits}, {2'h1, 7'h32, 4'h8});
    $display("test reset values done");
    for (int i = 0; i < 16; i++) begin
      d = 16'($urandom);
      d[15:11] = {i[0], i[3:0]};
      bus(1'b1, dram_cfg_pkg::WAIT_CTRL_ADDR, d);
      bus(1'b0, dram_cfg_pkg::WAIT_CTRL_ADDR, 16'h0000);
      chk(q, d & 16'hF800);
      chk(wait_pullup_en, d[15]);
      chk(area02_wait_cycles, d[14:13] + 3'h1);
      chk(area6_wait_cycles, d[12:11] + 3'h1);
      chk(wait_cfg, d[15:11]);
    end
    $display("test wait register done");
    old = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      d = 16'($urandom);
      d[9:8] = i[1:0];
      e = dexp(old, d);
      bus(1'b1, dram_cfg_pkg::DRAM_CTRL_ADDR, d);
      bus(1'b0, dram_cfg_pkg::DRAM_CTRL_ADDR, 16'h0000);
      chk(q, e);
      chk(precharge_cycles, e[13] ? 2'h2 : 2'h1);
      chk(col_strobe_high_pct, e[11] ? 7'h23 : 7'h32);
      chk(row_shift_bits, 4'h8 + e[9:8]);
      chk(dram_cfg, e[15:8]);
      old = e;
    end
    bus(1'b0, dram_cfg_pkg::DRAM_CTRL_ADDR + 32'h8, 16'h0000);
    chk(r, 2'h2);
    chk(q, 32'h00000000);
    bus(1'b1, dram_cfg_pkg::DRAM_CTRL_ADDR + 32'h8, 16'hFFFF);
    bus(1'b0, dram_cfg_pkg::DRAM_CTRL_ADDR, 16'h0000);
    chk(q, old);
    $display("test dram register done");
    for (int s = 0; s < 2; s++) begin
      bus(1'b1, dram_cfg_pkg::DRAM_CTRL_ADDR, {s[0], 15'h0000});
      for (int k = 0; k < 16; k++) begin
        {lane_lo, lane_hi, write_req, col_strobe_req} <= k[3:0];
        repeat (2) @(posedge clock);
        chk({col_strobe_high_byte_n, col_strobe_low_byte_n, write_strobe_high_byte_n,
             write_strobe_low_byte_n}, sexp(s[0], k[3:0]));
      end
    end
    $display("test strobes done");
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, dram_cfg_pkg::DRAM_CTRL_ADDR, {5'h00, i[0], 2'(i / 2), 8'h00});
      for (int k = 0; k < 4; k++) begin
        a = 28'($urandom);
        access_addr <= a; row_phase <= k[0];
        repeat (2) @(posedge clock);
        chk(dram_addr_out, (i[0] && k[0]) ? a >> (8 + i / 2) : a);
        chk(burst_row_addr, a >> (8 + i / 2));
      end
    end
    $display("test address done");
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, dram_cfg_pkg::WAIT_CTRL_ADDR, {1'b1, k[1:0], k[1:0], 11'h000});
      for (int j = 0; j < 4; j++) begin
        seq((j == 3) ? 3'h6 : 3'(j), 1'b0, 5'h00);
        chk(c, (j == 1) ? 2 : 3 + k);
      end
      seq(3'h6, 1'b1, 5'h00);
      chk(c, 3 + k);
      seq(3'h0, 1'b1, 5'h0C);
      chk(c > 3 + k && c < 20, 1'b1);
    end
    $display("test sequencer done");
    tally_and_finish();
  end
endmodule  // tb
`default_nettype wire
